// ===== pmcc_params.svh
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH

// register byte offsets
`define PMCC_OFS_MODE      12'h000
`define PMCC_OFS_OSC       12'h004
`define PMCC_OFS_STATUS    12'h008
`define PMCC_OFS_GATE0     12'h010
`define PMCC_OFS_GATE1     12'h014
`define PMCC_OFS_GATE2     12'h018
`define PMCC_OFS_GATE3     12'h01C
`define PMCC_OFS_CMD       12'h020

// mode register fields
`define PMCC_MODE_SEL_LO   0
`define PMCC_MODE_SEL_HI   1
`define PMCC_MODE_IDLE     2
`define PMCC_MODE_XTAL     3
// osc register fields
`define PMCC_OSC_FREQ_LO   0
`define PMCC_OSC_FREQ_HI   2
`define PMCC_OSC_SRC       3
`define PMCC_OSC_MID       4
`define PMCC_OSC_WDOG      5
`define PMCC_OSC_FSCM      6
// status register fields
`define PMCC_ST_PRI        0
`define PMCC_ST_HF_STABLE  1
`define PMCC_ST_MF_STABLE  2
`define PMCC_ST_CPU_RUN    3
`define PMCC_ST_IN_RESET   4
`define PMCC_ST_MODE_LO    8
// command register: write 1 to execute sleep
`define PMCC_CMD_SLEEP     0

`define PMCC_MODE_RESET    32'h0000_0000
`define PMCC_OSC_RESET     32'h0000_0000
`define PMCC_GATE_RESET    8'h00

// timing
`define PMCC_CLK_MHZ       200
`define PMCC_POWER_UP_TIMER_US       64000
`define PMCC_POWER_UP_TIMER_CYC      (`PMCC_POWER_UP_TIMER_US * `PMCC_CLK_MHZ)
`define PMCC_OST_CYC       1024
`define PMCC_CSD_NS        10
`define PMCC_CSD_CYC       ((`PMCC_CSD_NS * `PMCC_CLK_MHZ + 999) / 1000)
`define PMCC_SETTLE_NS     10
`define PMCC_SETTLE_CYC    ((`PMCC_SETTLE_NS * `PMCC_CLK_MHZ + 999) / 1000)

`endif

// ===== pmcc_pkg.sv
package pmcc_pkg;

	typedef enum logic [2:0] {
		pmcc_run_primary,
		pmcc_run_secondary,
		pmcc_run_internal,
		pmcc_idle_primary,
		pmcc_idle_secondary,
		pmcc_idle_internal,
		pmcc_sleep
	} pmcc_mode_t;

	typedef enum logic [1:0] {
		pmcc_ph_power_up_timer,
		pmcc_ph_ost,
		pmcc_ph_csd,
		pmcc_ph_ready
	} pmcc_phase_t;

	typedef enum logic [1:0] {
		pmcc_src_primary,
		pmcc_src_secondary,
		pmcc_src_internal,
		pmcc_src_none
	} pmcc_src_t;

	// ahb address phase captured for the data phase
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
	} pmcc_ahb_req_t;

	typedef struct packed {
		logic        primary_osc_en;
		logic        secondary_osc_en;
		logic        internal_osc_en;
		logic        low_freq_rc_en;
		pmcc_src_t   sys_src;
		logic        cpu_clk_en;
		logic        periph_clk_en;
		logic        core_reset;
	} pmcc_clk_ctl_t;

endpackage : pmcc_pkg

// ===== pmcc_clock_control.sv
// Notes on behaviour
// - primary-idle keeps the primary oscillator running without interruption.
// - every other low-power mode stops the primary oscillator pin.
// - secondary run and idle clock the device from the secondary oscillator.
// - internal run and idle clock the device from the internal block.
// - low-frequency internal clock usable directly, may stay on in any mode.
// - sleep stops the primary and secondary oscillators and every device clock.
// - internal oscillator stays on in sleep while the watchdog runs.
// - power-up timer holds reset about 64 ms, always enabled.
// - crystal modes count 1024 oscillator cycles before clocking the device.
// - after power-on reset a clock-switch delay precedes execution.
// - internal idle stops cpu clock, peripherals still clocked.
// - switching to internal mux stops primary and clears primary status.
// - internal output on outside sleep for nonzero freq, source bit or mid bit; flags after settle.
// - stable flags survive sleep entry when already stable and enabled.
// - freq, source and mid bits clear: output off unless watchdog runs in sleep, flags clear, no source shown.
// - peripherals stay clocked while internal source stabilises.
// - wake from internal idle: cpu resumes after clock-switch delay.
// - wake leaves idle bit and select bits unchanged.
// - low-freq rc runs while watchdog or fail-safe monitor enabled.
// - clearing a peripheral enable stops function, registers stay usable.
// - disable bit gates all clocks, blocks writes, reads invalid; four regs.
`include "pmcc_params.svh"

module pmcc_clock_control #(
	parameter int unsigned POWER_UP_TIMER_CYCLES = `PMCC_POWER_UP_TIMER_CYC,
	parameter int unsigned OST_CYCLES  = `PMCC_OST_CYC,
	parameter int unsigned NUM_PERIPH  = 32
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic                  primary_osc_tick,
	input  wire logic                  wake_event,
	input  wire logic [NUM_PERIPH-1:0] peripheral_enable_bit,
	output pmcc_pkg::pmcc_clk_ctl_t    clk_ctl,
	output logic [NUM_PERIPH-1:0]      periph_clk_gate_en,
	output logic [NUM_PERIPH-1:0]      periph_run,
	output logic [NUM_PERIPH-1:0]      periph_reg_access_en
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		pmcc_pkg::pmcc_ahb_req_t req;
		logic [31:0]             rdata;
		logic [3:0]              mode_reg;
		logic [6:0]              osc_reg;
		logic [31:0]             gate;
		pmcc_pkg::pmcc_mode_t    mode;
		pmcc_pkg::pmcc_phase_t   phase;
		logic [31:0]             cnt;
		logic [15:0]             settle_cnt;
		logic                    stable;
		logic                    primary_status;
		pmcc_pkg::pmcc_clk_ctl_t ctl;
	} pmcc_state_t;

	pmcc_state_t st;
	pmcc_state_t next_st;

	localparam logic [15:0] SETTLE_CYC = 16'(`PMCC_SETTLE_CYC);
	localparam logic [31:0] CSD_CYC    = 32'(`PMCC_CSD_CYC);

	function automatic logic internal_req(input logic [6:0] osc);
		return (osc[`PMCC_OSC_FREQ_HI:`PMCC_OSC_FREQ_LO] != 3'h0)
			|| osc[`PMCC_OSC_SRC] || osc[`PMCC_OSC_MID];
	endfunction : internal_req

	function automatic logic is_internal(input pmcc_pkg::pmcc_mode_t m);
		return m == pmcc_pkg::pmcc_run_internal
			|| m == pmcc_pkg::pmcc_idle_internal;
	endfunction : is_internal

	// run mode implied by the select bits; upper bit wins, lower ignored then
	function automatic pmcc_pkg::pmcc_mode_t run_of(input logic [3:0] mr);
		if (mr[`PMCC_MODE_SEL_HI])
			return pmcc_pkg::pmcc_run_internal;
		if (mr[`PMCC_MODE_SEL_LO])
			return pmcc_pkg::pmcc_run_secondary;
		return pmcc_pkg::pmcc_run_primary;
	endfunction : run_of

	// gate registers sit on consecutive words; the slot picks the byte lane
	function automatic logic [4:0] gate_lsb(input logic [11:0] a);
		return {a[3:2], 3'h0};
	endfunction : gate_lsb

	// internal mux with nothing requested shows no source at all
	function automatic pmcc_pkg::pmcc_src_t internal_src(input logic [6:0] osc);
		return internal_req(osc) ? pmcc_pkg::pmcc_src_internal
			: pmcc_pkg::pmcc_src_none;
	endfunction : internal_src

	// status word; the stable flag is split by the mid-frequency select
	function automatic logic [31:0] status_word(input pmcc_state_t s);
		logic [31:0] w;
		w                        = 32'h0;
		w[`PMCC_ST_PRI]          = s.primary_status;
		w[`PMCC_ST_HF_STABLE]    = s.stable && !s.osc_reg[`PMCC_OSC_MID];
		w[`PMCC_ST_MF_STABLE]    = s.stable && s.osc_reg[`PMCC_OSC_MID];
		w[`PMCC_ST_CPU_RUN]      = s.ctl.cpu_clk_en;
		w[`PMCC_ST_IN_RESET]     = s.ctl.core_reset;
		w[`PMCC_ST_MODE_LO +: 3] = s.mode;
		return w;
	endfunction : status_word

	// enables and source per mode; every field is set in every branch so
	// that no mode can inherit an enable left over from the one before
	function automatic pmcc_pkg::pmcc_clk_ctl_t ctl_of(
		input pmcc_pkg::pmcc_mode_t  m,
		input pmcc_pkg::pmcc_phase_t ph,
		input logic [6:0]            osc
	);
		pmcc_pkg::pmcc_clk_ctl_t c;
		logic                    held;
		logic                    ready;
		held  = ph == pmcc_pkg::pmcc_ph_power_up_timer || ph == pmcc_pkg::pmcc_ph_ost;
		ready = ph == pmcc_pkg::pmcc_ph_ready;
		c.core_reset     = held;
		c.low_freq_rc_en = osc[`PMCC_OSC_WDOG] || osc[`PMCC_OSC_FSCM]
			|| osc[`PMCC_OSC_SRC];
		case (m)
			pmcc_pkg::pmcc_run_primary: begin
				c.primary_osc_en   = 1'b1;
				c.secondary_osc_en = 1'b0;
				c.internal_osc_en  = internal_req(osc);
				c.sys_src          = pmcc_pkg::pmcc_src_primary;
				c.cpu_clk_en       = ready;
				c.periph_clk_en    = !held;
			end
			pmcc_pkg::pmcc_idle_primary: begin
				c.primary_osc_en   = 1'b1;
				c.secondary_osc_en = 1'b0;
				c.internal_osc_en  = internal_req(osc);
				c.sys_src          = pmcc_pkg::pmcc_src_primary;
				c.cpu_clk_en       = 1'b0;
				c.periph_clk_en    = !held;
			end
			pmcc_pkg::pmcc_run_secondary: begin
				c.primary_osc_en   = 1'b0;
				c.secondary_osc_en = 1'b1;
				c.internal_osc_en  = internal_req(osc);
				c.sys_src          = pmcc_pkg::pmcc_src_secondary;
				c.cpu_clk_en       = ready;
				c.periph_clk_en    = !held;
			end
			pmcc_pkg::pmcc_idle_secondary: begin
				c.primary_osc_en   = 1'b0;
				c.secondary_osc_en = 1'b1;
				c.internal_osc_en  = internal_req(osc);
				c.sys_src          = pmcc_pkg::pmcc_src_secondary;
				c.cpu_clk_en       = 1'b0;
				c.periph_clk_en    = !held;
			end
			pmcc_pkg::pmcc_run_internal: begin
				c.primary_osc_en   = 1'b0;
				c.secondary_osc_en = 1'b0;
				c.internal_osc_en  = internal_req(osc);
				c.sys_src          = internal_src(osc);
				c.cpu_clk_en       = ready;
				c.periph_clk_en    = !held;
			end
			pmcc_pkg::pmcc_idle_internal: begin
				c.primary_osc_en   = 1'b0;
				c.secondary_osc_en = 1'b0;
				c.internal_osc_en  = internal_req(osc);
				c.sys_src          = internal_src(osc);
				c.cpu_clk_en       = 1'b0;
				c.periph_clk_en    = !held;
			end
			pmcc_pkg::pmcc_sleep: begin
				c.primary_osc_en   = 1'b0;
				c.secondary_osc_en = 1'b0;
				c.internal_osc_en  = osc[`PMCC_OSC_WDOG];
				c.sys_src          = pmcc_pkg::pmcc_src_none;
				c.cpu_clk_en       = 1'b0;
				c.periph_clk_en    = 1'b0;
			end
			default: begin
				c.primary_osc_en   = 1'b1;
				c.secondary_osc_en = 1'b0;
				c.internal_osc_en  = 1'b0;
				c.sys_src          = pmcc_pkg::pmcc_src_primary;
				c.cpu_clk_en       = 1'b0;
				c.periph_clk_en    = 1'b0;
			end
		endcase
		return c;
	endfunction : ctl_of

	////////////////////////////////////////////////////////////////////////
	// next state

	logic                    addr_ok;
	pmcc_pkg::pmcc_mode_t    run_mode;
	logic                    sleep_cmd;

	always_comb begin
		next_st   = st;
		addr_ok   = hsel && hready && htrans[1];
		run_mode  = run_of(st.mode_reg);
		sleep_cmd = 1'b0;

		// bus data phase: registers take effect one cycle after address
		next_st.req.wr   = addr_ok && hwrite;
		next_st.req.rd   = addr_ok && !hwrite;
		next_st.req.addr = haddr[11:0];
		if (st.req.wr) begin
			case (st.req.addr)
				`PMCC_OFS_MODE: next_st.mode_reg = hwdata[3:0];
				`PMCC_OFS_OSC:  next_st.osc_reg  = hwdata[6:0];
				`PMCC_OFS_GATE0, `PMCC_OFS_GATE1,
				`PMCC_OFS_GATE2, `PMCC_OFS_GATE3:
					next_st.gate[gate_lsb(st.req.addr) +: 8] =
						hwdata[7:0];
				`PMCC_OFS_CMD:  sleep_cmd = hwdata[`PMCC_CMD_SLEEP];
				default: ;
			endcase
		end

		// power-up sequence
		case (st.phase)
			pmcc_pkg::pmcc_ph_power_up_timer: begin
				if (st.cnt >= POWER_UP_TIMER_CYCLES - 1) begin
					next_st.cnt = 32'h0;
					next_st.phase = st.mode_reg[`PMCC_MODE_XTAL]
						? pmcc_pkg::pmcc_ph_ost : pmcc_pkg::pmcc_ph_csd;
				end else
					next_st.cnt = st.cnt + 32'h1;
			end
			pmcc_pkg::pmcc_ph_ost: begin
				if (primary_osc_tick) begin
					if (st.cnt >= OST_CYCLES - 1) begin
						next_st.cnt   = 32'h0;
						next_st.phase = pmcc_pkg::pmcc_ph_csd;
					end else
						next_st.cnt = st.cnt + 32'h1;
				end
			end
			pmcc_pkg::pmcc_ph_csd: begin
				if (st.cnt >= CSD_CYC - 1) begin
					next_st.cnt   = 32'h0;
					next_st.phase = pmcc_pkg::pmcc_ph_ready;
				end else
					next_st.cnt = st.cnt + 32'h1;
			end
			pmcc_pkg::pmcc_ph_ready: ;
			default: next_st.phase = pmcc_pkg::pmcc_ph_power_up_timer;
		endcase

		// power-managed mode machine
		if (st.phase == pmcc_pkg::pmcc_ph_ready) begin
			case (st.mode)
				pmcc_pkg::pmcc_run_primary,
				pmcc_pkg::pmcc_run_secondary,
				pmcc_pkg::pmcc_run_internal: begin
					if (sleep_cmd) begin
						if (!st.mode_reg[`PMCC_MODE_IDLE])
							next_st.mode = pmcc_pkg::pmcc_sleep;
						else if (run_mode == pmcc_pkg::pmcc_run_internal)
							next_st.mode = pmcc_pkg::pmcc_idle_internal;
						else if (run_mode == pmcc_pkg::pmcc_run_secondary)
							next_st.mode = pmcc_pkg::pmcc_idle_secondary;
						else
							next_st.mode = pmcc_pkg::pmcc_idle_primary;
					end else
						next_st.mode = run_mode;
				end
				pmcc_pkg::pmcc_idle_primary,
				pmcc_pkg::pmcc_idle_secondary,
				pmcc_pkg::pmcc_idle_internal,
				pmcc_pkg::pmcc_sleep: begin
					// select bits untouched by wake
					if (wake_event) begin
						next_st.mode  = run_mode;
						next_st.phase = pmcc_pkg::pmcc_ph_csd;
						next_st.cnt   = 32'h0;
					end
				end
				default: next_st.mode = pmcc_pkg::pmcc_run_primary;
			endcase
		end

		// internal oscillator settling; flags kept across sleep when stable
		if (!internal_req(st.osc_reg)) begin
			next_st.stable     = 1'b0;
			next_st.settle_cnt = 16'h0;
		end else if (!st.stable) begin
			if (st.settle_cnt >= SETTLE_CYC - 16'h1)
				next_st.stable = 1'b1;
			else
				next_st.settle_cnt = st.settle_cnt + 16'h1;
		end

		// primary oscillator status
		if (is_internal(next_st.mode) || next_st.mode == pmcc_pkg::pmcc_sleep
				|| next_st.mode == pmcc_pkg::pmcc_idle_secondary
				|| next_st.mode == pmcc_pkg::pmcc_run_secondary)
			next_st.primary_status = 1'b0;
		else
			next_st.primary_status = next_st.phase == pmcc_pkg::pmcc_ph_ready
				|| st.primary_status;

		// clock control outputs; peripherals run in every mode but sleep once core reset is released
		next_st.ctl = ctl_of(next_st.mode, next_st.phase, st.osc_reg);

		// read data for the next data phase
		next_st.rdata = 32'h0;
		if (addr_ok && !hwrite) begin
			case (haddr[11:0])
				`PMCC_OFS_MODE: next_st.rdata = {28'h0, st.mode_reg};
				`PMCC_OFS_OSC:  next_st.rdata = {25'h0, st.osc_reg};
				`PMCC_OFS_STATUS: next_st.rdata = status_word(st);
				`PMCC_OFS_GATE0, `PMCC_OFS_GATE1,
				`PMCC_OFS_GATE2, `PMCC_OFS_GATE3:
					next_st.rdata =
						{24'h0, st.gate[gate_lsb(haddr[11:0]) +: 8]};
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st.req         <= '0;
			st.rdata       <= 32'h0;
			st.mode_reg    <= 4'(`PMCC_MODE_RESET);
			st.osc_reg     <= 7'(`PMCC_OSC_RESET);
			st.gate        <= {4{`PMCC_GATE_RESET}};
			st.mode        <= pmcc_pkg::pmcc_run_primary;
			st.phase       <= pmcc_pkg::pmcc_ph_power_up_timer;
			st.cnt         <= 32'h0;
			st.settle_cnt  <= 16'h0;
			st.stable      <= 1'b0;
			st.primary_status <= 1'b0;
			st.ctl         <= '{primary_osc_en: 1'b1, secondary_osc_en: 1'b0,
				internal_osc_en: 1'b0, low_freq_rc_en: 1'b0,
				sys_src: pmcc_pkg::pmcc_src_primary, cpu_clk_en: 1'b0,
				periph_clk_en: 1'b0, core_reset: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign hrdata    = st.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign clk_ctl   = st.ctl;

	// disabled module: no clock, no register access; enable bit only stops it
	always_comb begin
		for (int i = 0; i < NUM_PERIPH; i++) begin
			periph_clk_gate_en[i]   = st.ctl.periph_clk_en && !st.gate[i];
			periph_reg_access_en[i] = !st.gate[i];
			periph_run[i]           = periph_clk_gate_en[i]
				&& peripheral_enable_bit[i];
		end
	end

endmodule : pmcc_clock_control

// ===== pmcc_clock_control_asserts.sv
module pmcc_clock_control_asserts #(
	parameter int unsigned POWER_UP_TIMER_CYCLES = 50,
	parameter int unsigned NUM_PERIPH  = 32
) (
	input wire logic                    hclk,
	input wire logic                    hresetn,
	input wire logic                    wake_event,
	input wire logic [NUM_PERIPH-1:0]   peripheral_enable_bit,
	input wire pmcc_pkg::pmcc_clk_ctl_t clk_ctl,
	input wire logic [NUM_PERIPH-1:0]   periph_clk_gate_en,
	input wire logic [NUM_PERIPH-1:0]   periph_run,
	input wire logic [NUM_PERIPH-1:0]   periph_reg_access_en
);
	int unsigned up_cnt;

	// saturating count of cycles since reset let go
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			up_cnt <= 0;
		else if (up_cnt < POWER_UP_TIMER_CYCLES)
			up_cnt <= up_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	power_up_timer_hold_a: assert property (
		up_cnt + 1 < POWER_UP_TIMER_CYCLES |-> clk_ctl.core_reset)
		else $error("core left reset before power-up time");
	switch_delay_a: assert property (
		$fell(clk_ctl.core_reset) |->
		!clk_ctl.cpu_clk_en ##[1:4] clk_ctl.cpu_clk_en)
		else $error("cpu clock not delayed after reset");
	wake_resume_a: assert property (
		$rose(wake_event) && !clk_ctl.cpu_clk_en && !clk_ctl.core_reset
		|-> ##[1:8] clk_ctl.cpu_clk_en)
		else $error("cpu did not resume after wake");
	wake_periph_a: assert property (
		$rose(wake_event) && clk_ctl.periph_clk_en && !clk_ctl.cpu_clk_en
		|-> clk_ctl.periph_clk_en [*3])
		else $error("peripheral clock dropped on wake");
	sleep_stop_a: assert property (
		clk_ctl.sys_src == pmcc_pkg::pmcc_src_none && !clk_ctl.core_reset
		|-> !clk_ctl.primary_osc_en && !clk_ctl.secondary_osc_en)
		else $error("oscillator running with no source");
	primary_off_a: assert property (
		clk_ctl.sys_src inside {pmcc_pkg::pmcc_src_secondary,
		pmcc_pkg::pmcc_src_internal} |-> !clk_ctl.primary_osc_en)
		else $error("primary oscillator left running");
	sec_source_a: assert property (
		clk_ctl.sys_src == pmcc_pkg::pmcc_src_secondary
		|-> clk_ctl.secondary_osc_en)
		else $error("secondary source without its oscillator");
	int_source_a: assert property (
		clk_ctl.sys_src == pmcc_pkg::pmcc_src_internal
		|-> clk_ctl.internal_osc_en || clk_ctl.low_freq_rc_en)
		else $error("internal source without internal oscillator");
	run_gate_a: assert property (
		(periph_run & ~(periph_clk_gate_en & peripheral_enable_bit)) == '0)
		else $error("peripheral runs while disabled");
	reg_access_a: assert property (
		clk_ctl.periph_clk_en |-> periph_reg_access_en == periph_clk_gate_en)
		else $error("register access differs from clock gate");
endmodule : pmcc_clock_control_asserts

////////////////////////////////////////////////////////////////////////
bind pmcc_clock_control pmcc_clock_control_asserts #(
	.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES),
	.NUM_PERIPH (NUM_PERIPH)
) u_chk (
	.hclk                 (hclk),
	.hresetn              (hresetn),
	.wake_event           (wake_event),
	.peripheral_enable_bit(peripheral_enable_bit),
	.clk_ctl              (clk_ctl),
	.periph_clk_gate_en   (periph_clk_gate_en),
	.periph_run           (periph_run),
	.periph_reg_access_en (periph_reg_access_en)
);

// ===== power_managed_clock_control_tb_top.sv
`include "pmcc_params.svh"

module power_managed_clock_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// short power-up and start-up counts keep the run brief
	localparam int unsigned POWER_UP_TIMER = 50;
	localparam int unsigned STARTUP_CYCLE_COUNTER  = 8;
	logic                    hclk, hresetn, hsel, hwrite, tick, wake;
	logic                    hreadyout, hresp;
	logic [1:0]              htrans;
	logic [2:0]              hsize;
	logic [31:0]             haddr, hwdata, hrdata, pen, gate, run, acc;
	pmcc_pkg::pmcc_clk_ctl_t ctl;
	int                      error_cnt, checks_done;

	pmcc_clock_control #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER), .OST_CYCLES(STARTUP_CYCLE_COUNTER),
		.NUM_PERIPH(32)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .primary_osc_tick(tick), .wake_event(wake),
		.peripheral_enable_bit(pen), .clk_ctl(ctl),
		.periph_clk_gate_en(gate), .periph_run(run),
		.periph_reg_access_en(acc));

	////////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	task chk(string n, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task hang(string n);
		error_cnt++;
		$display("unexpected %s expected done seen timeout", n);
		print_verdict();
	endtask : hang
	task cyc(int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task wready;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 40);
		if (k >= 40) hang("hreadyout");
	endtask : wready
	task wr(logic [11:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		haddr <= {20'h0, a};
		wready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wready();
	endtask : wr
	// read data is taken at the edge that closes the data phase
	task rd(logic [11:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b0;
		haddr <= {20'h0, a};
		wready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		wready();
		d = hrdata;
	endtask : rd
	task rchk(string n, logic [11:0] a, logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(n, e, v);
	endtask : rchk
	task wait_ctl(bit cpu, logic v);
		int k;
		k = 0;
		while ((cpu ? ctl.cpu_clk_en : ctl.core_reset) !== v && k < 200) begin
			@(posedge hclk);
			k++;
		end
		if (k >= 200) hang("clk_ctl");
	endtask : wait_ctl
	task wake_up;
		wake <= 1'b1;
		@(posedge hclk);
		wake <= 1'b0;
		wait_ctl(1, 1'b1);
		chk("periph_clk_en", 1, ctl.periph_clk_en);
	endtask : wake_up
	task sleep_cmd;
		wr(`PMCC_OFS_CMD, 32'h1);
		cyc(8);
	endtask : sleep_cmd

	////////////////////////////////////////////////////////////////////
	task t_startup;
		for (int i = 0; i < 4; i++)
			rchk("gate_reg", `PMCC_OFS_GATE0 + 12'(4 * i), 0);
		wr(`PMCC_OFS_MODE, 32'h8);
		cyc(POWER_UP_TIMER + 4);
		chk("core_reset", 1, ctl.core_reset);
		repeat (STARTUP_CYCLE_COUNTER - 1) begin
			tick <= 1'b1;
			@(posedge hclk);
			tick <= 1'b0;
			@(posedge hclk);
		end
		cyc(2);
		chk("core_reset", 1, ctl.core_reset);
		tick <= 1'b1;
		@(posedge hclk);
		tick <= 1'b0;
		wait_ctl(0, 1'b0);
		wait_ctl(1, 1'b1);
		$display("test startup done");
	endtask : t_startup
	task t_gate;
		wr(`PMCC_OFS_GATE0, 32'h01);
		wr(`PMCC_OFS_GATE3, 32'h80);
		pen <= 32'hFFFF_FFFD;
		cyc(3);
		chk("gate_en", 32'h7FFF_FFFE, gate);
		chk("reg_access", 32'h7FFF_FFFE, acc);
		chk("run", 32'h7FFF_FFFC, run);
		rchk("gate3", `PMCC_OFS_GATE3, 32'h80);
		rchk("unmapped", 12'hFFC, 0);
		chk("hresp", 0, {31'h0, hresp});
		wr(`PMCC_OFS_GATE0, 0);
		wr(`PMCC_OFS_GATE3, 0);
		pen <= 32'hFFFF_FFFF;
		cyc(3);
		chk("gate_en", 32'hFFFF_FFFF, gate);
		$display("test gate done");
	endtask : t_gate
	task t_osc;
		logic [31:0] v;
		wr(`PMCC_OFS_OSC, 32'h7);
		cyc(6);
		chk("internal_osc_en", 1, ctl.internal_osc_en);
		rd(`PMCC_OFS_STATUS, v);
		chk("hf_stable", 1, v[1]);
		wr(`PMCC_OFS_OSC, 0);
		cyc(6);
		chk("internal_osc_en", 0, ctl.internal_osc_en);
		rd(`PMCC_OFS_STATUS, v);
		chk("stable_flags", 0, v[2:1]);
		foreach (v[i]) if (i == 5 || i == 6) begin
			wr(`PMCC_OFS_OSC, 32'h1 << i);
			cyc(4);
			chk("low_freq_rc_en", 1, ctl.low_freq_rc_en);
		end
		wr(`PMCC_OFS_OSC, 32'h27);
		cyc(6);
		$display("test osc done");
	endtask : t_osc
	task t_internal_idle_mode;
		logic [31:0] v;
		wr(`PMCC_OFS_MODE, 32'hC);
		wr(`PMCC_OFS_MODE, 32'hE);
		sleep_cmd();
		chk("sys_src", 2, ctl.sys_src);
		chk("cpu_clk_en", 0, ctl.cpu_clk_en);
		chk("periph_clk_en", 1, ctl.periph_clk_en);
		chk("primary_osc_en", 0, ctl.primary_osc_en);
		rd(`PMCC_OFS_STATUS, v);
		chk("status", 32'h2, v & 32'h3);
		wake_up();
		rchk("mode", `PMCC_OFS_MODE, 32'hE);
		sleep_cmd();
		chk("cpu_clk_en", 0, ctl.cpu_clk_en);
		wake_up();
		wr(`PMCC_OFS_MODE, 32'hA);
		sleep_cmd();
		chk("osc_pri_sec", 0, {ctl.primary_osc_en, ctl.secondary_osc_en});
		chk("clk_en", 0, {ctl.cpu_clk_en, ctl.periph_clk_en});
		chk("internal_osc_en", 1, ctl.internal_osc_en);
		wake_up();
		$display("test internal idle done");
	endtask : t_internal_idle_mode
	task t_sec_pri;
		wr(`PMCC_OFS_MODE, 32'h1);
		cyc(8);
		chk("sys_src", 1, ctl.sys_src);
		chk("secondary_osc_en", 1, ctl.secondary_osc_en);
		wr(`PMCC_OFS_MODE, 32'h5);
		sleep_cmd();
		chk("secondary_idle_mode", 32'h2, {ctl.sys_src, ctl.primary_osc_en});
		wake_up();
		wr(`PMCC_OFS_MODE, 32'h4);
		sleep_cmd();
		chk("sys_src", 0, ctl.sys_src);
		chk("primary_osc_en", 1, ctl.primary_osc_en);
		wake_up();
		$display("test secondary primary done");
	endtask : t_sec_pri

	////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, tick, wake, htrans} = '0;
		{haddr, hwdata} = '0;
		hsize = 3'h2;
		pen = 32'hFFFF_FFFF;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_startup();
		t_gate();
		t_osc();
		t_internal_idle_mode();
		t_sec_pri();
		print_verdict();
	end
endmodule : power_managed_clock_control_tb_top
